// >>> pkg/scan_pkg.sv
package scan_pkg;

	// ****************************************************************
	// widths and counts
	// ****************************************************************
	localparam int DATA_W     = 32;
	localparam int POS_W      = 24;
	localparam int ADDR_W     = 8;
	localparam int BE_W       = 4;
	localparam int AXES       = 3;
	localparam int CHAN_COUNT = 4;

	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_KEY       = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_CMD_BASE  = 8'h10;
	localparam logic [7:0] OFS_COMP_BASE = 8'h14;
	localparam logic [7:0] CHAN_STRIDE   = 8'h08;

	// ****************************************************************
	// control fields
	// ****************************************************************
	localparam int BIT_SEND_EN  = 19;
	localparam int BIT_PARITY   = 18;
	localparam int BIT_CLK_SEL  = 17;
	localparam int BIT_SYNC     = 16;
	localparam int FMT_HI       = 15;
	localparam int FMT_LO       = 14;
	localparam int TYPE_HI      = 15;
	localparam int TYPE_LO      = 13;
	localparam int BIT_EDGE     = 12;
	localparam int BIT_TX_VALID = 11;
	localparam int POS_LSB      = 8;

	localparam logic [31:0] CTRL_MASK_A = 32'h000F_C000;
	localparam logic [31:0] CTRL_MASK_B = 32'h000B_F800;
	localparam logic [31:0] DATA_MASK   = 32'hFFFF_FF00;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

	localparam logic [1:0] FMT_16 = 2'h0;
	localparam logic [1:0] FMT_18 = 2'h1;
	localparam logic [1:0] FMT_20 = 2'h2;
	localparam logic [23:0] MASK_16 = 24'h00_FFFF;
	localparam logic [23:0] MASK_18 = 24'h03_FFFF;
	localparam logic [23:0] MASK_20 = 24'h0F_FFFF;
	localparam logic [23:0] MASK_24 = 24'hFF_FFFF;

	localparam logic [2:0] TYPE_POS = 3'h1;
	localparam logic [2:0] TYPE_CMD = 3'h7;

	// ****************************************************************
	// status fields
	// ****************************************************************
	localparam int STAT_UNLOCKED = 0;
	localparam int STAT_SENDING  = 1;
	localparam int STAT_VARIANT  = 2;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_NS      = 50;
	localparam int TICK_NS     = 10000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
	localparam int INTERP_SHIFT = 3;
	localparam logic [3:0] INTERP_STEPS = 4'h8;

	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

// >>> pkg/axis_if.sv
`timescale 1ns/1ps
interface axis_if;
	import scan_pkg::*;
	logic                    tick;
	logic                    load;
	logic signed [POS_W-1:0] target;
	logic signed [POS_W-1:0] comp;
	logic signed [POS_W-1:0] sum;

	modport ctrl (output tick, output load, output target, output comp,
		input sum);
	modport axis (input tick, input load, input target, input comp,
		output sum);
endinterface

// >>> verilog/axis_interp.sv
`timescale 1ns/1ps
module axis_interp
	import scan_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset,
	axis_if.axis      link
);
	logic signed [POS_W-1:0] cur_reg;
	logic signed [POS_W-1:0] goal_reg;
	logic signed [POS_W-1:0] step_reg;
	logic        [3:0]       remain_reg;
	logic signed [POS_W:0]   diff;
	logic signed [POS_W:0]   diff_shift;

	// one extra bit so a full-range move cannot wrap before the shift
	assign diff       = {link.target[POS_W-1], link.target}
		- {cur_reg[POS_W-1], cur_reg};
	assign diff_shift = diff >>> INTERP_SHIFT;

	// interpolated point is held; offset is added only on the way out
	assign link.sum = cur_reg + link.comp;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cur_reg    <= '0;
			goal_reg   <= '0;
			step_reg   <= '0;
			remain_reg <= '0;
		end else if (link.load) begin
			goal_reg   <= link.target;
			step_reg   <= diff_shift[POS_W-1:0];
			remain_reg <= INTERP_STEPS;
		end else if (link.tick && remain_reg != 4'h0) begin
			remain_reg <= remain_reg - 4'h1;
			// last step lands exactly on the goal, no shift residue
			cur_reg <= (remain_reg == 4'h1) ? goal_reg
				: cur_reg + step_reg;
		end
	end
endmodule

// >>> verilog/scan_ctrl_regs.sv
// What this block does
// - the control register only takes a write right after the key.
// - control bit 19 low stops all sending, high lets words go out.
// - in variant A bit 18 picks even (0) or odd (1) sent parity.
// - bit 17 picks the servo (0) or phase (1) clock as reference.
// - bit 16 picks asynchronous (0) or synchronous (1) interpolation.
// - in variant A bits 15..14 pick 16, 18 or 20 bit positions.
// - in variant B bits 15..13 mark a position (001) or command (111).
// - in variant B bit 12 picks falling (0) or rising (1) clock edge.
// - in variant B bit 11 marks the sent data valid or disabled.
// - channels 0, 1, 2 hold the X, Y, Z axes and channel 3 is empty.
// - in variant A the position lives in bits 31..8, low byte zero.
// - in variant B bits 31..8 are a position or a raw command.
// - each axis has a signed offset added to its interpolated point.
// - the interpolated point refreshes every 10 us before offset.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module scan_ctrl_regs
	import scan_pkg::*;
#(
	parameter logic              VARIANT_B  = 1'b0,
	// arbitrary unlock value
	parameter logic [DATA_W-1:0] UNLOCK_KEY = 32'h0000_5A3C
)(
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [BE_W-1:0]   avs_byteenable,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              servo_clk,
	input  wire logic              phase_clk,
	output logic                   tx_strobe,
	output logic                   tx_valid,
	output logic      [2:0]        tx_type,
	output logic      [AXES-1:0]   tx_parity,
	output logic      [POS_W-1:0]  tx_x_data,
	output logic      [POS_W-1:0]  tx_y_data,
	output logic      [POS_W-1:0]  tx_z_data
);
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// ****************************************************************
	// bus slave
	// ****************************************************************
	bus_state_t        bus_state_reg;
	bus_state_t        bus_state_next;
	logic              wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] ctrl_reg;
	logic              unlock_reg;
	logic [DATA_W-1:0] be_mask;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] rd_terms [AXES];
	logic [AXES-1:0]   cmd_wr;

	wire req     = avs_read || avs_write;
	wire accept  = (bus_state_reg == BUS_ANSWER);
	wire wr_fire = accept && avs_write;
	wire hit_ctl = (avs_address == OFS_CONTROL);
	wire hit_key = (avs_address == OFS_KEY);
	wire hit_sts = (avs_address == OFS_STATUS);

	genvar b;
	generate
		for (b = 0; b < BE_W; b++) begin : g_be
			assign be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
		end
	endgenerate

	wire [DATA_W-1:0] wr_ctl  = (ctrl_reg & ~be_mask)
		| (avs_writedata & be_mask);
	wire [DATA_W-1:0] ctl_msk = VARIANT_B ? CTRL_MASK_B : CTRL_MASK_A;
	wire key_ok = (avs_writedata == UNLOCK_KEY) && (&avs_byteenable);

	always_comb begin
		bus_state_next = BUS_IDLE;
		if (bus_state_reg == BUS_IDLE && req) begin
			bus_state_next = BUS_ANSWER;
		end
	end

	// a request is answered one edge after it is seen
	always_comb begin
		rdata_next = '0;
		if (hit_ctl) begin
			rdata_next = ctrl_reg;
		end else if (hit_sts) begin
			rdata_next = status_word;
		end
		for (int i = 0; i < AXES; i++) begin
			rdata_next = rdata_next | rd_terms[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bus_state_reg <= BUS_IDLE;
			wait_reg      <= 1'b1;
			rdata_reg     <= '0;
		end else begin
			bus_state_reg <= bus_state_next;
			wait_reg      <= (bus_state_next != BUS_ANSWER);
			rdata_reg     <= rdata_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;

	// ****************************************************************
	// key and control register
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			unlock_reg <= 1'b0;
			ctrl_reg   <= RESET_VALUE;
		end else if (wr_fire && hit_key) begin
			unlock_reg <= key_ok;
		end else if (wr_fire && hit_ctl) begin
			// one key opens exactly one control write
			unlock_reg <= 1'b0;
			if (unlock_reg) begin
				ctrl_reg <= wr_ctl & ctl_msk;
			end
		end
	end

	wire       send_en  = ctrl_reg[BIT_SEND_EN];
	wire       par_odd  = !VARIANT_B && ctrl_reg[BIT_PARITY];
	wire       clk_sel  = ctrl_reg[BIT_CLK_SEL];
	wire       sync_md  = ctrl_reg[BIT_SYNC];
	wire [1:0] fmt_sel  = ctrl_reg[FMT_HI:FMT_LO];
	wire [2:0] type_sel = ctrl_reg[TYPE_HI:TYPE_LO];
	wire       edge_sel = !VARIANT_B || ctrl_reg[BIT_EDGE];
	wire       raw_cmd  = VARIANT_B && (type_sel == TYPE_CMD);

	assign status_word = {{(DATA_W-3){1'b0}}, VARIANT_B, send_en,
		unlock_reg};

	// ****************************************************************
	// timing reference and 10 us refresh
	// ****************************************************************
	logic       ref_prev_reg;
	logic [7:0] tick_cnt_reg;
	logic       tick_reg;

	// servo and phase clocks arrive synchronous to sys_clk
	wire ref_lvl  = clk_sel ? phase_clk : servo_clk;
	wire ref_rise = ref_lvl && !ref_prev_reg;
	wire ref_fall = !ref_lvl && ref_prev_reg;
	wire ref_edge = edge_sel ? ref_rise : ref_fall;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ref_prev_reg <= 1'b0;
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else begin
			ref_prev_reg <= ref_lvl;
			tick_reg     <= (tick_cnt_reg == TICK_LAST);
			tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 8'h00
				: tick_cnt_reg + 8'h01;
		end
	end

	// synchronous mode takes new targets on the reference edge only,
	// asynchronous mode at the next refresh tick
	wire load_evt = sync_md ? ref_edge : tick_reg;

	// ****************************************************************
	// per axis command and offset registers
	// ****************************************************************
	axis_if link [AXES] ();
	logic [POS_W-1:0] word [AXES];

	wire [23:0] fmt_mask = VARIANT_B ? MASK_24
		: (fmt_sel == FMT_18) ? MASK_18
		: (fmt_sel == FMT_20) ? MASK_20
		: MASK_16;

	genvar a;
	generate
		for (a = 0; a < AXES; a++) begin : g_axis
			logic [DATA_W-1:0] cmd_reg;
			logic [DATA_W-1:0] comp_reg;
			logic              dirty_reg;
			wire [7:0] cmd_ofs  = OFS_CMD_BASE + 8'(a) * CHAN_STRIDE;
			wire [7:0] comp_ofs = OFS_COMP_BASE + 8'(a) * CHAN_STRIDE;
			wire hit_cmd  = (avs_address == cmd_ofs);
			wire hit_comp = (avs_address == comp_ofs);
			wire [DATA_W-1:0] wr_cmd  = (cmd_reg & ~be_mask)
				| (avs_writedata & be_mask);
			wire [DATA_W-1:0] wr_comp = (comp_reg & ~be_mask)
				| (avs_writedata & be_mask);

			assign cmd_wr[a] = wr_fire && hit_cmd;

			always_ff @(posedge sys_clk) begin
				if (reset) begin
					cmd_reg   <= RESET_VALUE;
					comp_reg  <= RESET_VALUE;
					dirty_reg <= 1'b0;
				end else begin
					if (cmd_wr[a]) begin
						cmd_reg <= wr_cmd & DATA_MASK;
					end
					if (wr_fire && hit_comp) begin
						comp_reg <= wr_comp & DATA_MASK;
					end
					// a write in the load cycle keeps the flag set
					if (cmd_wr[a]) begin
						dirty_reg <= 1'b1;
					end else if (load_evt) begin
						dirty_reg <= 1'b0;
					end
				end
			end

			assign rd_terms[a] = hit_cmd ? cmd_reg
				: hit_comp ? comp_reg : '0;

			assign link[a].tick   = tick_reg;
			assign link[a].load   = load_evt && dirty_reg && !raw_cmd;
			assign link[a].target = cmd_reg[DATA_W-1:POS_LSB];
			assign link[a].comp   = comp_reg[DATA_W-1:POS_LSB];

			// a control command bypasses interpolation and offset
			assign word[a] = (raw_cmd ? cmd_reg[DATA_W-1:POS_LSB]
				: link[a].sum) & fmt_mask;

			axis_interp u_interp (
				.sys_clk (sys_clk),
				.reset   (reset),
				.link    (link[a])
			);
		end
	endgenerate

	// ****************************************************************
	// words toward the scanner
	// ****************************************************************
	logic             strobe_reg;
	logic             valid_reg;
	logic [2:0]       type_reg;
	logic [AXES-1:0]  par_reg;
	logic [POS_W-1:0] x_reg;
	logic [POS_W-1:0] y_reg;
	logic [POS_W-1:0] z_reg;

	wire [AXES-1:0] par_next = {^word[2] ^ par_odd, ^word[1] ^ par_odd,
		^word[0] ^ par_odd};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strobe_reg <= 1'b0;
			valid_reg  <= 1'b0;
			type_reg   <= '0;
			par_reg    <= '0;
			x_reg      <= '0;
			y_reg      <= '0;
			z_reg      <= '0;
		end else begin
			strobe_reg <= tick_reg && send_en;
			valid_reg  <= send_en
				&& (!VARIANT_B || ctrl_reg[BIT_TX_VALID]);
			if (tick_reg && send_en) begin
				type_reg <= VARIANT_B ? type_sel : 3'h0;
				par_reg  <= par_next;
				x_reg    <= word[0];
				y_reg    <= word[1];
				z_reg    <= word[2];
			end
		end
	end

	assign tx_strobe = strobe_reg;
	assign tx_valid  = valid_reg;
	assign tx_type   = type_reg;
	assign tx_parity = par_reg;
	assign tx_x_data = x_reg;
	assign tx_y_data = y_reg;
	assign tx_z_data = z_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	// the next tick lands exactly one refresh period after the last
	localparam int tick_gap = TICK_CYCLES - 1;

	sequence s_req_seen;
		req && bus_state_reg == BUS_IDLE;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	chk_bus_answer: assert property (s_req_seen |=> s_answer)
		else $error("bus request not answered in one cycle");
	chk_key_guard: assert property (
		wr_fire && hit_ctl && !unlock_reg |=> $stable(ctrl_reg))
		else $error("locked control register changed");
	chk_send_gate: assert property (!send_en |=> !tx_strobe)
		else $error("word sent while sending is stopped");
	chk_parity_sense: assert property (
		tx_strobe |-> (^tx_x_data ^ tx_parity[0]) == $past(par_odd))
		else $error("sent parity does not match selection");
	chk_sync_load: assert property (
		sync_md && !ref_edge && !raw_cmd |-> !link[0].load)
		else $error("synchronous load off the reference edge");
	chk_async_load: assert property (
		!sync_md && g_axis[0].dirty_reg && tick_reg && !cmd_wr[0]
		|=> !g_axis[0].dirty_reg)
		else $error("asynchronous target not taken on refresh");
	chk_format_mask: assert property (
		tx_strobe && !VARIANT_B && $past(fmt_sel) == FMT_16
		|-> tx_x_data[23:16] == 8'h00)
		else $error("16 bit word carries upper bits");
	chk_type_out: assert property (
		tick_reg && send_en
		|=> tx_type == (VARIANT_B ? $past(type_sel) : 3'h0))
		else $error("word type differs from control field");
	chk_valid_mark: assert property (
		VARIANT_B && !ctrl_reg[BIT_TX_VALID] |=> !tx_valid)
		else $error("data marked valid while disabled");
	chk_reserved_zero: assert property (
		(s_req_seen and (avs_read && !hit_sts))
		|=> (avs_readdata & ~DATA_MASK & ~ctl_msk) == '0)
		else $error("reserved bits read as one");
	chk_tick_period: assert property (
		tick_reg |=> !tick_reg ##[tick_gap:tick_gap] tick_reg)
		else $error("refresh tick period wrong");
endmodule

// >>> bench/scanner_model.sv
`timescale 1ns/1ps
module scanner_model
	import scan_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic ref_run,
	input  wire logic tx_strobe,
	input  wire logic tx_valid,
	output logic      servo_clk,
	output logic      phase_clk,
	output int        gap_bad,
	output int        strobe_cnt
);
	int div;
	int gap;

	// ****************************************************************
	// reference clocks
	// ****************************************************************
	// the phase clock can be halted while the servo clock keeps running,
	// so a block that follows the wrong reference is caught
	always @(posedge sys_clk) begin
		if (reset) begin
			div       <= 0;
			servo_clk <= 1'b0;
			phase_clk <= 1'b0;
		end else begin
			div <= (div == 39) ? 0 : div + 1;
			if (div == 0)
				servo_clk <= ~servo_clk;
			if (ref_run && div % 10 == 0)
				phase_clk <= ~phase_clk;
		end
	end

	// ****************************************************************
	// word reception
	// ****************************************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			strobe_cnt <= 0;
			gap_bad    <= 0;
			gap        <= 0;
		end else begin
			if (tx_strobe)
				strobe_cnt <= strobe_cnt + 1;
			if (!tx_valid) begin
				gap <= 0;
			end else if (tx_strobe) begin
				if (gap != 0 && gap != TICK_CYCLES)
					gap_bad <= gap_bad + 1;
				gap <= 1;
			end else if (gap != 0) begin
				gap <= gap + 1;
			end
		end
	end
endmodule

// >>> bench/scan_ctrl_regs_tb.sv
`timescale 1ns/1ps
module scan_ctrl_regs_tb;
	import scan_pkg::*;
	localparam logic [31:0] KEY = 32'h0000_5A3C;
	logic              sys_clk;
	logic              reset;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [DATA_W-1:0] avs_writedata;
	logic [BE_W-1:0]   avs_byteenable;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              servo_clk;
	logic              phase_clk;
	logic              ref_run;
	logic              tx_strobe;
	logic              tx_valid;
	logic [2:0]        tx_type;
	logic [POS_W-1:0]  tx_data [AXES];
	logic [AXES-1:0]   tx_parity;
	int                gap_bad;
	int                strobe_cnt;
	int                err_count;
	int                n_tests;
	int                seed;
	int                snap;
	int                pos [AXES];
	int                off [AXES];
	logic [DATA_W-1:0] ctrl;
	logic [POS_W-1:0]  old_w;

	scan_ctrl_regs #(.VARIANT_B(1'b0), .UNLOCK_KEY(KEY)) scan_ctrl_regs_i (
		.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.servo_clk(servo_clk), .phase_clk(phase_clk),
		.tx_strobe(tx_strobe), .tx_valid(tx_valid), .tx_type(tx_type),
		.tx_parity(tx_parity), .tx_x_data(tx_data[0]),
		.tx_y_data(tx_data[1]), .tx_z_data(tx_data[2]));

	scanner_model scanner_model_i (
		.sys_clk(sys_clk), .reset(reset), .ref_run(ref_run),
		.tx_strobe(tx_strobe), .tx_valid(tx_valid),
		.servo_clk(servo_clk), .phase_clk(phase_clk),
		.gap_bad(gap_bad), .strobe_cnt(strobe_cnt));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************************************
	// reporting and comparison
	// ****************************************************************
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic fail(input string msg);
		err_count++;
		$display("unexpected %0t %s", $time, msg);
	endtask

	task automatic check_reg(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp)
			fail(m);
	endtask

	function automatic logic [POS_W-1:0] model(input int a);
		logic [POS_W-1:0] s;
		s = POS_W'(pos[a] + off[a]);
		return s & ~(24'hFF_FFFF << (16 + 2 * ctrl[15:14]));
	endfunction

	task automatic check_tx(input int a, input logic [POS_W-1:0] e);
		n_tests++;
		if (tx_data[a] !== e || tx_parity[a] !== (^e ^ ctrl[18])
			|| tx_type !== 3'h0 || tx_valid !== 1'b1)
			fail("scanner word");
	endtask

	// ****************************************************************
	// register bus
	// ****************************************************************
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 20) begin
			fail("bus hang");
			final_report();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check_reg(q, e, "register read");
	endtask

	task automatic set_ctrl(input logic [31:0] v);
		wr(OFS_KEY, KEY);
		wr(OFS_CONTROL, v);
		ctrl = v & 32'h000F_C000;
	endtask

	task automatic wait_strobes(input int n);
		int t;
		t = strobe_cnt + n;
		for (int i = 0; i < n * 220 && strobe_cnt < t; i++)
			@(posedge sys_clk);
		if (strobe_cnt < t) begin
			fail("no strobe");
			final_report();
		end
		@(posedge sys_clk);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		seed = 32'hC62C_AC8A;
		err_count = 0;
		n_tests = 0;
		ctrl = 32'h0000_0000;
		reset = 1'b1;
		ref_run = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		wr(8'h28, 32'h1234_5600);
		wr(8'h3C, 32'hFFFF_FF00);
		for (int a = 0; a < 'h40; a += 4)
			if (a != OFS_KEY)
				rd_chk(8'(a), 32'h0000_0000);
		$display("reset and map test done");
		wr(OFS_CONTROL, 32'h000F_4000);
		rd_chk(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_KEY, ~KEY);
		wr(OFS_CONTROL, 32'h000F_4000);
		rd_chk(OFS_CONTROL, 32'h0000_0000);
		set_ctrl(32'hFFF6_BFFF);
		rd_chk(OFS_CONTROL, 32'h0006_8000);
		wr(OFS_CONTROL, 32'h0000_0000);
		rd_chk(OFS_CONTROL, 32'h0006_8000);
		$display("key test done");
		snap = strobe_cnt;
		repeat (2 * TICK_CYCLES + 50) @(posedge sys_clk);
		check_reg(32'(strobe_cnt - snap), 32'h0, "sent while off");
		$display("send gate test done");
		for (int f = 0; f < 3; f++) begin
			for (int p = 0; p < 2; p++) begin
				set_ctrl(32'h0008_0000 | (p << 18) | (f << 14));
				for (int a = 0; a < AXES; a++) begin
					pos[a] = $random(seed) % (1 << 23);
					off[a] = $random(seed) % 4096;
					wr(OFS_CMD_BASE + 8'(a * 8), 32'(pos[a] << 8) | 32'hA5);
					wr(OFS_COMP_BASE + 8'(a * 8), 32'(off[a] << 8));
					rd_chk(OFS_CMD_BASE + 8'(a * 8), 32'(pos[a] << 8));
				end
				wait_strobes(12);
				for (int a = 0; a < AXES; a++)
					check_tx(a, model(a));
			end
		end
		$display("format parity offset test done");
		ref_run <= 1'b0;
		set_ctrl(32'h000B_8000);
		rd_chk(OFS_STATUS, 32'h0000_0002);
		old_w = model(0);
		pos[0] = $random(seed) % (1 << 23);
		wr(OFS_CMD_BASE, 32'(pos[0] << 8));
		wait_strobes(12);
		check_tx(0, old_w);
		ref_run <= 1'b1;
		wait_strobes(12);
		check_tx(0, model(0));
		$display("sync reference test done");
		set_ctrl(32'h0000_8000);
		// a strobe launched as the stop lands is counted one edge later
		@(posedge sys_clk);
		snap = strobe_cnt;
		repeat (2 * TICK_CYCLES + 50) @(posedge sys_clk);
		check_reg(32'(strobe_cnt - snap), 32'h0, "sent after stop");
		check_reg(32'(gap_bad), 32'h0, "strobe spacing");
		check_reg(32'(tx_valid), 32'h0, "valid after stop");
		$display("stop test done");
		final_report();
	end
endmodule
